// ===== io_bus_defines.svh
`ifndef IO_BUS_DEFINES_SVH
`define IO_BUS_DEFINES_SVH

// Address split for parity
`define ADDR_HI_MSB          35
`define ADDR_HI_LSB          24
`define ADDR_LO_MSB          23
`define ADDR_LO_LSB          3
// Widths
`define REQ_CODE_W           5
`define RESP_CODE_W          3
`define DATA_W               64
`define CHECK_W              8
// Delay from bus reset to delayed processor reset, in bus clocks
`define CPU_RESET_DELAY      8
`define CPU_RESET_CNT_W      4
// Response code idle value (active-low wires all high)
`define RESP_IDLE_N          3'h7

`endif

// ===== io_bus_pkg.sv
package io_bus_pkg;
  typedef logic [35:3] bus_addr_t;
  typedef logic [4:0]  req_code_t;
  typedef logic [2:0]  resp_code_t;
  typedef logic [63:0] data_word_t;
  typedef logic [7:0]  check_t;

  // Parity: even convention, so parity bit is XOR of the group
  function automatic logic even_par_addr_hi(input bus_addr_t a);
    even_par_addr_hi = ^a[35:24];
  endfunction : even_par_addr_hi

  function automatic logic even_par_addr_lo(input bus_addr_t a);
    even_par_addr_lo = ^a[23:3];
  endfunction : even_par_addr_lo

  // ECC check bits: simple per-byte parity over each data byte
  function automatic check_t data_check(input data_word_t d);
    check_t c;
    c = 8'h00;
    for (int i = 0; i < 8; i++) begin
      c[i] = ^d[i*8 +: 8];
    end
    data_check = c;
  endfunction : data_check
endpackage : io_bus_pkg

// ===== io_bus_if.sv
`timescale 1ns/100ps
// Shared bus wires; all active-low signals are carried in their wire sense.
interface io_bus_if;
  // Request group
  logic                   request_address_strobe_n;
  io_bus_pkg::bus_addr_t  addr;
  logic [1:0]             address_parity_bits_n;
  io_bus_pkg::req_code_t  req_code_n;
  logic                   request_parity_n;
  logic                   address_parity_fault_n;
  // Arbitration
  logic                   block_next_request_n;
  logic                   priority_agent_request_n;
  logic                   lock_n;
  // Snoop and response
  logic                   snoop_clean_hit_n;
  logic                   snoop_dirty_hit_n;
  logic                   postpone_n;
  io_bus_pkg::resp_code_t response_code_n;
  logic                   response_parity_n;
  logic                   target_ready_n;
  // Data
  logic                   data_bus_hold_n;
  logic                   data_valid_n;
  io_bus_pkg::data_word_t data;
  io_bus_pkg::check_t     data_check_bits_n;
  logic                   bus_data_fault_n;
  // Reset and power
  logic                   bus_reset_n;
  logic                   delayed_cpu_reset_n;
  logic                   carrier_power_ok;
  logic                   system_power_ok;

  // Bridge end: issues requests, drives reset and power-good
  modport bridge (
    output request_address_strobe_n, addr, address_parity_bits_n,
           req_code_n, request_parity_n, lock_n, bus_reset_n,
           delayed_cpu_reset_n, carrier_power_ok, system_power_ok,
    input  address_parity_fault_n, block_next_request_n,
           priority_agent_request_n, snoop_clean_hit_n, snoop_dirty_hit_n,
           postpone_n, response_code_n, response_parity_n, target_ready_n,
           data_bus_hold_n, data_valid_n, data, data_check_bits_n,
           bus_data_fault_n
  );
  // Controller end: checks requests, snoops, responds, supplies data
  modport controller (
    input  request_address_strobe_n, addr, address_parity_bits_n,
           req_code_n, request_parity_n, lock_n, bus_reset_n,
           delayed_cpu_reset_n, carrier_power_ok, system_power_ok,
    output address_parity_fault_n, block_next_request_n,
           priority_agent_request_n, snoop_clean_hit_n, snoop_dirty_hit_n,
           postpone_n, response_code_n, response_parity_n, target_ready_n,
           data_bus_hold_n, data_valid_n, data, data_check_bits_n,
           bus_data_fault_n
  );
endinterface : io_bus_if

// ===== io_bridge_agent.sv
`timescale 1ns/100ps
`include "io_bus_defines.svh"
// Function
// - Strobe only in first request cycle
// - Address parity: hi 35-24, lo 23-3
// - Flag parity fault on address/request mismatch
// - Request parity over strobe and code[3:0]
// - Response parity over response code
// - Hold new requests while blocked
// - Priority agent owns request bus next
// - Cycle one type, cycle two size/length
// - Hold data bus across multi-cycle transfer
// - Data-valid only in transfer cycles
// - Postpone when in-order completion impossible
// - Clean hit for unmodified copy
// - Dirty hit, then supply the line
// - Both hits together extend snoop window
// - Atomic signal held across whole sequence
// - Target-ready marks valid response cycle
// - Delayed processor reset eight clocks later
// - Only primary bridge drives bus reset
// - All bus signals on clock rising edge
// - Carrier power-good drops on panel reset
// - System power-good low until supplies good
// - 64 data plus 8 check bits
module io_bridge_agent #(
  parameter int RESET_DELAY = `CPU_RESET_DELAY
) (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   reset,
  // Power and reset inputs (pins)
  input  wire logic                   panel_reset_req,
  input  wire logic                   supplies_ok,
  input  wire logic                   bus_reset_req,
  // Request port
  input  wire logic                   req_valid,
  input  wire io_bus_pkg::bus_addr_t  req_addr,
  input  wire io_bus_pkg::req_code_t  req_type,
  input  wire io_bus_pkg::req_code_t  req_size_len,
  input  wire logic                   req_atomic,
  output logic                        req_ready,
  // Completion port
  output logic                        resp_valid,
  output io_bus_pkg::resp_code_t      resp_code,
  output logic                        resp_parity_bad,
  output logic                        resp_postponed,
  output logic                        rd_valid,
  output io_bus_pkg::data_word_t      rd_data,
  output logic                        rd_check_bad,
  output logic                        parity_fault_seen,
  // Bus
  io_bus_if.bridge                    bus
);
  typedef enum logic [1:0] {REQ_IDLE, REQ_SECOND} req_state_t;

  // Pin synchronisers
  logic [2:0] pin_meta_reg, pin_sync_reg;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pin_meta_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
    end else begin
      pin_meta_reg <= {panel_reset_req, supplies_ok, bus_reset_req};
      pin_sync_reg <= pin_meta_reg;
    end
  end
  wire panel_rst_s = pin_sync_reg[2];
  wire supplies_s  = pin_sync_reg[1];
  wire bus_rst_s   = pin_sync_reg[0];

  // Reset and power-good sequencing
  logic                          bus_reset_n_reg, bus_reset_n_next;
  logic [`CPU_RESET_CNT_W-1:0]   rst_cnt_reg, rst_cnt_next;
  logic                          cpu_rst_n_reg, cpu_rst_n_next;
  logic                          carrier_ok_reg, carrier_ok_next;
  logic                          sys_ok_reg, sys_ok_next;
  always_comb begin
    sys_ok_next      = supplies_s;
    carrier_ok_next  = supplies_s && !panel_rst_s;
    bus_reset_n_next = !(bus_rst_s || panel_rst_s || !supplies_s);
    rst_cnt_next     = rst_cnt_reg;
    cpu_rst_n_next   = cpu_rst_n_reg;
    if (!bus_reset_n_reg) begin
      // Count from bus reset assertion; delayed reset follows
      if (rst_cnt_reg < RESET_DELAY[`CPU_RESET_CNT_W-1:0]) begin
        rst_cnt_next = rst_cnt_reg + 1'b1;
      end
      if (rst_cnt_reg == RESET_DELAY[`CPU_RESET_CNT_W-1:0] - 1'b1) begin
        cpu_rst_n_next = 1'b0;
      end
    end else begin
      rst_cnt_next   = '0;
      cpu_rst_n_next = 1'b1;
    end
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      bus_reset_n_reg <= 1'b0;
      rst_cnt_reg     <= '0;
      cpu_rst_n_reg   <= 1'b1;
      carrier_ok_reg  <= 1'b0;
      sys_ok_reg      <= 1'b0;
    end else begin
      bus_reset_n_reg <= bus_reset_n_next;
      rst_cnt_reg     <= rst_cnt_next;
      cpu_rst_n_reg   <= cpu_rst_n_next;
      carrier_ok_reg  <= carrier_ok_next;
      sys_ok_reg      <= sys_ok_next;
    end
  end

  // Request phase
  req_state_t              st_reg, st_next;
  logic                    ads_n_reg, ads_n_next;
  io_bus_pkg::bus_addr_t   addr_reg, addr_next;
  logic [1:0]              ap_n_reg, ap_n_next;
  io_bus_pkg::req_code_t   code_n_reg, code_n_next, size_hold_reg,
                           size_hold_next;
  logic                    rp_n_reg, rp_n_next;
  logic                    lock_n_reg, lock_n_next;
  logic                    ready_reg, ready_next;
  wire blocked = !bus.block_next_request_n
              || !bus.priority_agent_request_n;
  always_comb begin
    st_next        = st_reg;
    ads_n_next     = 1'b1;
    addr_next      = addr_reg;
    ap_n_next      = ap_n_reg;
    code_n_next    = 5'h1F;
    size_hold_next = size_hold_reg;
    rp_n_next      = 1'b1;
    lock_n_next    = req_atomic ? 1'b0 : 1'b1;
    ready_next     = 1'b0;
    case (st_reg)
      REQ_IDLE: begin
        if (req_valid && !blocked && bus_reset_n_reg) begin
          st_next        = REQ_SECOND;
          ads_n_next     = 1'b0;
          addr_next      = req_addr;
          // Wire is active low: invert the even parity bit
          ap_n_next      = ~{io_bus_pkg::even_par_addr_hi(req_addr),
                             io_bus_pkg::even_par_addr_lo(req_addr)};
          code_n_next    = ~req_type;
          size_hold_next = req_size_len;
          rp_n_next      = ~(1'b1 ^ (^req_type[3:0]));
          ready_next     = 1'b1;
        end
      end
      REQ_SECOND: begin
        st_next     = REQ_IDLE;
        code_n_next = ~size_hold_reg;
        rp_n_next   = ~(^size_hold_reg[3:0]);
      end
      default: st_next = REQ_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_reg        <= REQ_IDLE;
      ads_n_reg     <= 1'b1;
      addr_reg      <= '0;
      ap_n_reg      <= 2'h3;
      code_n_reg    <= 5'h1F;
      size_hold_reg <= '0;
      rp_n_reg      <= 1'b1;
      lock_n_reg    <= 1'b1;
      ready_reg     <= 1'b0;
    end else begin
      st_reg        <= st_next;
      ads_n_reg     <= ads_n_next;
      addr_reg      <= addr_next;
      ap_n_reg      <= ap_n_next;
      code_n_reg    <= code_n_next;
      size_hold_reg <= size_hold_next;
      rp_n_reg      <= rp_n_next;
      lock_n_reg    <= lock_n_next;
      ready_reg     <= ready_next;
    end
  end

  // Response and data capture; controller wires share this clock
  logic                    rv_reg, rv_next, rpb_reg, rpb_next, pp_reg, pp_next;
  io_bus_pkg::resp_code_t  rc_reg, rc_next;
  logic                    dv_reg, dv_next, cb_reg, cb_next, pf_reg, pf_next;
  io_bus_pkg::data_word_t  rd_reg, rd_next;
  always_comb begin
    rv_next  = !bus.target_ready_n;
    rc_next  = ~bus.response_code_n;
    rpb_next = !bus.target_ready_n &&
               ((^(~bus.response_code_n)) != !bus.response_parity_n);
    pp_next  = !bus.target_ready_n && !bus.postpone_n;
    dv_next  = !bus.data_valid_n;
    rd_next  = bus.data;
    cb_next  = !bus.data_valid_n && (io_bus_pkg::data_check(bus.data)
               != ~bus.data_check_bits_n);
    pf_next  = !bus.address_parity_fault_n;
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rv_reg <= 1'b0; rc_reg <= '0; rpb_reg <= 1'b0; pp_reg <= 1'b0;
      dv_reg <= 1'b0; rd_reg <= '0; cb_reg <= 1'b0; pf_reg <= 1'b0;
    end else begin
      rv_reg <= rv_next; rc_reg <= rc_next; rpb_reg <= rpb_next;
      pp_reg <= pp_next; dv_reg <= dv_next; rd_reg <= rd_next;
      cb_reg <= cb_next; pf_reg <= pf_next;
    end
  end

  // Outputs straight from flip-flops
  assign req_ready                    = ready_reg;
  assign resp_valid                   = rv_reg;
  assign resp_code                    = rc_reg;
  assign resp_parity_bad              = rpb_reg;
  assign resp_postponed               = pp_reg;
  assign rd_valid                     = dv_reg;
  assign rd_data                      = rd_reg;
  assign rd_check_bad                 = cb_reg;
  assign parity_fault_seen            = pf_reg;
  assign bus.request_address_strobe_n = ads_n_reg;
  assign bus.addr                     = addr_reg;
  assign bus.address_parity_bits_n    = ap_n_reg;
  assign bus.req_code_n               = code_n_reg;
  assign bus.request_parity_n         = rp_n_reg;
  assign bus.lock_n                   = lock_n_reg;
  assign bus.bus_reset_n              = bus_reset_n_reg;
  assign bus.delayed_cpu_reset_n      = cpu_rst_n_reg;
  assign bus.carrier_power_ok         = carrier_ok_reg;
  assign bus.system_power_ok          = sys_ok_reg;
endmodule : io_bridge_agent

// ===== io_controller_agent.sv
`timescale 1ns/100ps
`include "io_bus_defines.svh"
module io_controller_agent (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   reset,
  // Arbitration and snoop controls (same clock)
  input  wire logic                   block_req,
  input  wire logic                   priority_req,
  input  wire logic                   snoop_clean,
  input  wire logic                   snoop_dirty,
  input  wire logic                   snoop_stall,
  input  wire logic                   postpone,
  // Response port
  input  wire logic                   resp_go,
  input  wire io_bus_pkg::resp_code_t resp_code,
  input  wire logic [3:0]             resp_beats,
  input  wire io_bus_pkg::data_word_t resp_data,
  output logic                        data_take,
  // Observed request
  output logic                        req_valid,
  output io_bus_pkg::bus_addr_t       req_addr,
  output io_bus_pkg::req_code_t       req_type,
  output io_bus_pkg::req_code_t       req_size_len,
  output logic                        req_locked,
  output logic                        in_reset,
  // Bus
  io_bus_if.controller                bus
);
  typedef enum logic [1:0] {C_IDLE, C_SECOND, C_DATA} ctl_state_t;

  ctl_state_t             st_reg, st_next;
  io_bus_pkg::bus_addr_t  ra_reg, ra_next;
  io_bus_pkg::req_code_t  rt_reg, rt_next, rs_reg, rs_next;
  logic                   rv_reg, rv_next, perr1_reg, perr1_next;
  logic                   aerr_n_reg, aerr_n_next, lk_reg, lk_next;
  logic [3:0]             beats_reg, beats_next;
  logic                   trdy_n_reg, trdy_n_next, rsp_n_reg, rsp_n_next;
  io_bus_pkg::resp_code_t rs_n_reg, rs_n_next;
  logic                   dbsy_n_reg, dbsy_n_next, drdy_n_reg, drdy_n_next;
  io_bus_pkg::data_word_t d_reg, d_next;
  io_bus_pkg::check_t     dep_n_reg, dep_n_next;
  logic                   take_reg, take_next;
  logic                   hit_n_reg, hit_n_next, hitm_n_reg, hitm_n_next;
  logic                   bnr_n_reg, bnr_n_next, bpri_n_reg, bpri_n_next;
  logic                   def_n_reg, def_n_next, rst_reg, rst_next;

  // Request decode, parity checks, snoop and response sequencing
  always_comb begin
    st_next = st_reg; ra_next = ra_reg; rt_next = rt_reg; rs_next = rs_reg;
    rv_next = 1'b0; perr1_next = perr1_reg; aerr_n_next = 1'b1;
    lk_next = !bus.lock_n;
    beats_next = beats_reg; trdy_n_next = 1'b1; rs_n_next = `RESP_IDLE_N;
    rsp_n_next = 1'b1; dbsy_n_next = 1'b1; drdy_n_next = 1'b1;
    d_next = d_reg; dep_n_next = dep_n_reg; take_next = 1'b0;
    bnr_n_next  = !block_req;
    bpri_n_next = !priority_req;
    // Stall drives both hits for a longer snoop window
    hit_n_next  = !(snoop_clean || snoop_stall);
    hitm_n_next = !(snoop_dirty || snoop_stall);
    def_n_next  = !postpone;
    rst_next    = !bus.bus_reset_n;
    case (st_reg)
      C_IDLE: begin
        if (!bus.request_address_strobe_n) begin
          st_next = C_SECOND;
          ra_next = bus.addr;
          rt_next = ~bus.req_code_n;
          perr1_next =
            (~bus.address_parity_bits_n !=
             {io_bus_pkg::even_par_addr_hi(bus.addr),
              io_bus_pkg::even_par_addr_lo(bus.addr)}) ||
            ((^(~bus.req_code_n[3:0]) ^ 1'b1) != !bus.request_parity_n);
        end else if (resp_go) begin
          st_next     = C_DATA;
          beats_next  = resp_beats;
          trdy_n_next = 1'b0;
          rs_n_next   = ~resp_code;
          rsp_n_next  = ~(^resp_code);
          dbsy_n_next = (resp_beats > 4'h1) ? 1'b0 : 1'b1;
          drdy_n_next = (resp_beats == 4'h0);
          d_next      = resp_data;
          dep_n_next  = ~io_bus_pkg::data_check(resp_data);
          take_next   = (resp_beats != 4'h0);
        end
      end
      C_SECOND: begin
        st_next = C_IDLE;
        rs_next = ~bus.req_code_n;
        rv_next = 1'b1;
        aerr_n_next = !(perr1_reg ||
          ((^(~bus.req_code_n[3:0])) != !bus.request_parity_n));
      end
      C_DATA: begin
        if (beats_reg > 4'h1) begin
          beats_next  = beats_reg - 4'h1;
          dbsy_n_next = (beats_reg > 4'h2) ? 1'b0 : 1'b1;
          drdy_n_next = 1'b0;
          d_next      = resp_data;
          dep_n_next  = ~io_bus_pkg::data_check(resp_data);
          take_next   = 1'b1;
        end else begin
          st_next = C_IDLE;
        end
      end
      default: st_next = C_IDLE;
    endcase
    if (!bus.bus_reset_n) begin
      st_next = C_IDLE;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_reg <= C_IDLE; ra_reg <= '0; rt_reg <= '0; rs_reg <= '0;
      rv_reg <= 1'b0; perr1_reg <= 1'b0; aerr_n_reg <= 1'b1; lk_reg <= 1'b0;
      beats_reg <= '0; trdy_n_reg <= 1'b1; rs_n_reg <= `RESP_IDLE_N;
      rsp_n_reg <= 1'b1; dbsy_n_reg <= 1'b1; drdy_n_reg <= 1'b1;
      d_reg <= '0; dep_n_reg <= 8'hFF; take_reg <= 1'b0;
      hit_n_reg <= 1'b1; hitm_n_reg <= 1'b1; bnr_n_reg <= 1'b1;
      bpri_n_reg <= 1'b1; def_n_reg <= 1'b1; rst_reg <= 1'b1;
    end else begin
      st_reg <= st_next; ra_reg <= ra_next; rt_reg <= rt_next;
      rs_reg <= rs_next; rv_reg <= rv_next; perr1_reg <= perr1_next;
      aerr_n_reg <= aerr_n_next; lk_reg <= lk_next; beats_reg <= beats_next;
      trdy_n_reg <= trdy_n_next; rs_n_reg <= rs_n_next;
      rsp_n_reg <= rsp_n_next; dbsy_n_reg <= dbsy_n_next;
      drdy_n_reg <= drdy_n_next; d_reg <= d_next; dep_n_reg <= dep_n_next;
      take_reg <= take_next; hit_n_reg <= hit_n_next;
      hitm_n_reg <= hitm_n_next; bnr_n_reg <= bnr_n_next;
      bpri_n_reg <= bpri_n_next; def_n_reg <= def_n_next;
      rst_reg <= rst_next;
    end
  end

  // Outputs
  assign req_valid                    = rv_reg;
  assign req_addr                     = ra_reg;
  assign req_type                     = rt_reg;
  assign req_size_len                 = rs_reg;
  assign req_locked                   = lk_reg;
  assign in_reset                     = rst_reg;
  assign data_take                    = take_reg;
  assign bus.address_parity_fault_n   = aerr_n_reg;
  assign bus.block_next_request_n     = bnr_n_reg;
  assign bus.priority_agent_request_n = bpri_n_reg;
  assign bus.snoop_clean_hit_n        = hit_n_reg;
  assign bus.snoop_dirty_hit_n        = hitm_n_reg;
  assign bus.postpone_n               = def_n_reg;
  assign bus.response_code_n          = rs_n_reg;
  assign bus.response_parity_n        = rsp_n_reg;
  assign bus.target_ready_n           = trdy_n_reg;
  assign bus.data_bus_hold_n          = dbsy_n_reg;
  assign bus.data_valid_n             = drdy_n_reg;
  assign bus.data                     = d_reg;
  assign bus.data_check_bits_n        = dep_n_reg;
  assign bus.bus_data_fault_n         = 1'b1;
endmodule : io_controller_agent

// ===== io_bus_agent_interface_asserts.sv
`timescale 1ns/100ps
// Watches the wires between the bridge end and the controller end
module io_bus_agent_interface_checker (
  // Clock and reset
  input wire logic                  clk_sys,
  input wire logic                  reset,
  // Request and arbitration
  input wire logic                  request_address_strobe_n,
  input wire io_bus_pkg::bus_addr_t addr,
  input wire logic [1:0]            address_parity_bits_n,
  input wire logic                  block_next_request_n,
  input wire logic                  priority_agent_request_n,
  // Response and data
  input wire logic                  target_ready_n,
  input wire logic                  data_bus_hold_n,
  input wire logic                  data_valid_n,
  // Reset pair
  input wire logic                  bus_reset_n,
  input wire logic                  delayed_cpu_reset_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  // Request phase; wires at the taking edge decide if a strobe may follow
  AST_STROBE_ONE: assert property (!request_address_strobe_n |=>
    request_address_strobe_n) else $error("strobe too long");
  AST_ADDR_PAR: assert property (!request_address_strobe_n |->
    address_parity_bits_n == ~{^addr[35:24], ^addr[23:3]})
    else $error("address parity wrong");
  AST_BLOCKED: assert property (!$past(block_next_request_n) |->
    request_address_strobe_n) else $error("request while blocked");
  AST_PRIORITY: assert property (!$past(priority_agent_request_n) |->
    request_address_strobe_n) else $error("request during priority");
  // Response and beats
  AST_TRDY_ONE: assert property (!target_ready_n |=> target_ready_n)
    else $error("target ready too long");
  AST_HOLD_BEATS: assert property (!data_bus_hold_n |->
    !data_valid_n ##1 !data_valid_n) else $error("hold without beats");
  AST_LAST_BEAT: assert property (!data_valid_n && data_bus_hold_n |=>
    data_valid_n) else $error("beat after last");
  // Delayed reset lags the bus reset by eight clocks
  AST_CPU_RESET: assert property ($fell(bus_reset_n) |->
    delayed_cpu_reset_n [*7] ##[1:2] !delayed_cpu_reset_n)
    else $error("delayed reset timing wrong");
  // Main traffic seen
  cover property (!request_address_strobe_n);
  cover property (!data_bus_hold_n ##1 data_bus_hold_n);
  cover property ($fell(delayed_cpu_reset_n));
endmodule : io_bus_agent_interface_checker

// ===== io_bus_agent_interface_tb_top.sv
`timescale 1ns/100ps
module io_bus_agent_interface_tb_top;
  // User sides of both ends
  logic                   clk_sys, reset, supplies_ok, panel_reset_req;
  logic                   bus_reset_req, req_valid, req_atomic, req_ready;
  logic                   resp_valid, resp_parity_bad, resp_postponed, pf_seen;
  logic                   rd_valid, rd_check_bad, block_req, priority_req;
  logic                   snoop_clean, snoop_dirty, snoop_stall, postpone;
  logic                   resp_go, data_take, c_valid, req_locked, in_reset;
  logic [3:0]             resp_beats;
  io_bus_pkg::bus_addr_t  req_addr, c_addr;
  io_bus_pkg::req_code_t  req_type, req_size_len, c_type, c_size;
  io_bus_pkg::resp_code_t b_code, c_code;
  io_bus_pkg::data_word_t rd_data, resp_data;
  int                     fail_count, num_checks;

  io_bus_if bus ();
  io_bridge_agent io_bridge_agent_inst (.clk_sys, .reset, .panel_reset_req,
    .supplies_ok, .bus_reset_req, .req_valid, .req_addr, .req_type,
    .req_size_len, .req_atomic, .req_ready, .resp_valid, .resp_code(b_code),
    .resp_parity_bad, .resp_postponed, .rd_valid, .rd_data, .rd_check_bad,
    .parity_fault_seen(pf_seen), .bus(bus.bridge));
  io_controller_agent io_controller_agent_inst (.clk_sys, .reset, .block_req,
    .priority_req, .snoop_clean, .snoop_dirty, .snoop_stall, .postpone,
    .resp_go, .resp_code(c_code), .resp_beats, .resp_data, .data_take,
    .req_valid(c_valid), .req_addr(c_addr), .req_type(c_type),
    .req_size_len(c_size), .req_locked, .in_reset, .bus(bus.controller));
  io_bus_agent_interface_checker io_bus_agent_interface_checker_inst (
    .clk_sys, .reset, .addr(bus.addr),
    .request_address_strobe_n(bus.request_address_strobe_n),
    .address_parity_bits_n(bus.address_parity_bits_n),
    .block_next_request_n(bus.block_next_request_n),
    .priority_agent_request_n(bus.priority_agent_request_n),
    .target_ready_n(bus.target_ready_n), .data_valid_n(bus.data_valid_n),
    .data_bus_hold_n(bus.data_bus_hold_n), .bus_reset_n(bus.bus_reset_n),
    .delayed_cpu_reset_n(bus.delayed_cpu_reset_n));

  always #12.5 clk_sys = ~clk_sys;
  // Next word offered once a beat has gone out
  always @(negedge clk_sys)
    if (data_take === 1'b1)
      resp_data <= resp_data + 64'h1;

  task chk(string what, logic [63:0] exp, logic [63:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task tally_and_finish;
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  // Request held until taken; controller decode checked two cycles on
  task send(io_bus_pkg::bus_addr_t a, io_bus_pkg::req_code_t t, s,
            logic at);
    int n;
    @(negedge clk_sys);
    {req_addr, req_type, req_size_len, req_atomic} = {a, t, s, at};
    req_valid = 1'b1;
    n = 0;
    while (req_ready !== 1'b1 && n++ < 30) @(negedge clk_sys);
    req_valid = 1'b0;
    n = 0;
    while (c_valid !== 1'b1 && n++ < 6) @(negedge clk_sys);
    chk("decode", {a, t, s, at}, {c_addr, c_type, c_size, req_locked});
    chk("fault", 2'h2, {bus.address_parity_fault_n, pf_seen});
  endtask : send

  // One response of nb beats, watched at the bridge's user side
  task respond(io_bus_pkg::resp_code_t c, logic [3:0] nb, logic pp);
    logic [63:0] w;
    int k, r;
    @(negedge clk_sys);
    {postpone, c_code, resp_beats, resp_go} = {pp, c, nb, 1'b1};
    w = resp_data;
    @(negedge clk_sys);
    resp_go = 1'b0;
    k = 0;
    r = 0;
    for (int n = 0; n < 12; n++) begin
      if (resp_valid === 1'b1) begin
        r++;
        chk("response", {c, pp, 1'b0}, {b_code, resp_postponed,
            resp_parity_bad});
      end
      if (rd_valid === 1'b1) begin
        chk("beat", w + k, rd_data);
        chk("check bits", 1'b0, rd_check_bad);
        k++;
      end
      @(negedge clk_sys);
    end
    chk("responses", 1, r);
    chk("beats", nb, k);
    postpone = 1'b0;
  endtask : respond

  initial begin
    {clk_sys, reset, supplies_ok, panel_reset_req} = 4'h6;
    {bus_reset_req, req_valid, block_req, priority_req} = 4'h0;
    {snoop_clean, snoop_dirty, snoop_stall, postpone, resp_go} = 5'h00;
    {req_addr, req_type, req_size_len, req_atomic, c_code, resp_beats} = '0;
    resp_data = 64'h0123_4567_89ab_cdef;
    fail_count = 0;
    num_checks = 0;
    repeat (5) @(negedge clk_sys);
    chk("power in reset", 2'h0, {bus.system_power_ok, bus.bus_reset_n});
    reset = 1'b0;
    repeat (10) @(negedge clk_sys);
    chk("running", 3'h7, {bus.bus_reset_n, bus.delayed_cpu_reset_n,
        bus.carrier_power_ok});
    send(33'h1_ffff_ffff, 5'h1f, 5'h00, 1'b0);
    send(33'h0_0000_0008, 5'h0a, 5'h15, 1'b1);
    $display("test requests done");
    for (int i = 0; i < 2; i++) begin
      {priority_req, block_req} = i ? 2'h2 : 2'h1;
      fork
        send(33'h0_5555_aaaa, 5'h03, 5'h06, 1'b0);
        begin
          repeat (6) @(negedge clk_sys);
          chk("held off", 1'b0, req_ready);
          {priority_req, block_req} = 2'h0;
        end
      join
      $display("test hold off %0d done", i);
    end
    // Clean, dirty, then both together for a longer snoop
    for (int i = 0; i < 3; i++) begin
      {snoop_stall, snoop_dirty, snoop_clean} = 3'h1 << i;
      repeat (2) @(negedge clk_sys);
      chk("hits", 2'(~(i == 2 ? 2'h3 : 2'h1 << i)),
          {bus.snoop_dirty_hit_n, bus.snoop_clean_hit_n});
    end
    {snoop_stall, snoop_dirty, snoop_clean} = 3'h0;
    respond(3'h0, 4'h0, 1'b0);
    respond(3'h5, 4'h1, 1'b1);
    respond(3'h2, 4'h4, 1'b0);
    $display("test responses done");
    for (int i = 0; i < 2; i++) begin
      {panel_reset_req, bus_reset_req} = i ? 2'h2 : 2'h1;
      repeat (14) @(negedge clk_sys);
      chk("in bus reset", {2'h0, i == 0, 1'b1}, {bus.bus_reset_n,
          bus.delayed_cpu_reset_n, bus.carrier_power_ok, in_reset});
      {panel_reset_req, bus_reset_req} = 2'h0;
      repeat (8) @(negedge clk_sys);
      chk("reset over", 3'h6, {bus.bus_reset_n, bus.delayed_cpu_reset_n,
          in_reset});
      $display("test reset source %0d done", i);
    end
    tally_and_finish();
  end

  // Tests take under 150 cycles; far beyond that means a hang
  initial begin
    #(25 * 3000);
    fail_count++;
    tally_and_finish();
  end
endmodule : io_bus_agent_interface_tb_top
